// *** dcf_pkg.sv ***
// ============================================================
// shared constants and types of the clocked fifo
package dcf_pkg;
  // memory geometry
  localparam int DEPTH = 1024;
  localparam int AW = 10;
  localparam int PW = 11;
  localparam int DW = 36;
  localparam int OFS_W = 10;
  // control and timing counts
  localparam int CTL_W = 4;
  localparam int IR_ARM_EDGES = 2;
  localparam int RTX_MIN_READS = 2;
  // reset values of the flags
  localparam logic IR_RST = 1'b0;
  localparam logic OR_RST = 1'b0;
  localparam logic MAIL_FULL_N_RST = 1'b1;
  // port control bundle as sampled from the pins
  typedef struct packed {
    logic select_n;
    logic dir;
    logic strobe_en;
    logic mail_sel;
  } dcf_port_ctl_t;
  // retransmit state, one-hot
  typedef enum logic [1:0] {
    RTX_IDLE = 2'b01,
    RTX_ON = 2'b10
  } dcf_rtx_state_t;
endpackage

// *** dcf_pin_sync.sv ***
`timescale 1ns/1ps
// ============================================================
// three-stage sampler; a change is taken once stages 2 and 3 agree
module dcf_pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [W-1:0] i_pins,
  output logic [W-1:0] o_level
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] level_q;

  // sampling chain
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (i_ce) begin
      s1_q <= i_pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // agreement filter, bit by bit
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      level_q <= '0;
    end else if (i_ce) begin
      level_q <= (s2_q & s3_q) | (level_q & (s2_q | s3_q));
    end
  end

  assign o_level = level_q;
endmodule

// *** dcf_mailbox.sv ***
`timescale 1ns/1ps
// ============================================================
// one-word mailbox with an active-low full flag
module dcf_mailbox #(
  parameter int W = 36
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [W-1:0] i_data,
  output logic [W-1:0] o_data,
  output logic o_full_n
);
  logic [W-1:0] data_q;
  logic full_n_q;

  // store only while empty; contents survive a read
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      data_q <= '0;
    end else if (i_ce && i_wr && full_n_q) begin
      data_q <= i_data;
    end
  end

  // write drives the flag low and wins over a read in the same cycle
  always_ff @(posedge i_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      full_n_q <= dcf_pkg::MAIL_FULL_N_RST;
    end else if (i_ce) begin
      if (i_wr && full_n_q) begin
        full_n_q <= 1'b0;
      end else if (i_rd) begin
        full_n_q <= 1'b1;
      end
    end
  end

  assign o_data = data_q;
  assign o_full_n = full_n_q;
endmodule

// *** dcf_fifo.sv ***
`timescale 1ns/1ps
// ============================================================
// clocked fifo: port a writes, port b reads, with mailboxes
// Operation
// - port b direction is inverted: high reads, low writes mailbox
// - port b bus drives only with select low and direction high
// - selected port b fifo read with output ready loads next word
// - port b reads output register or a-to-b mailbox; read frees it
// - port a reads b-to-a mailbox; selected read frees that mailbox
// - output ready low: the edge raising it loads the word itself
// - every fifo flag passes two flop stages in its own port domain; mailbox flags pass none
// - word in the output register is not counted as stored
// - output ready low ignores fifo reads, old word stays
// - read pointer steps per load; new word lands third b edge
// - input ready low means full or not yet armed after reset; writes then ignored
// - input ready rises on second a edge after freeing read
// - almost empty low at offset count or fewer, high above
// - almost empty rises second b edge after crossing write
// - almost full low at 1024 minus offset or more words
// - almost full rises second a edge after crossing read
// - full: ready and almost full low; empty: read flags low
// - retransmit input with output ready marks the held word
// - retransmit lasts until its input is sampled low
// - replay after two reads reloads the marked word, repeatable
// - shadow pointer feeds write-side flags during retransmit
// - mailbox write sets full; writes ignored while full
// - reset clears pointers and sets the flags to rest values
module dcf_fifo (
  input wire logic I_MCLK,
  input wire logic I_RSTN,
  input wire logic I_CE,
  input wire logic I_PORT_A_CLK,
  input wire logic I_PORT_A_SELECT_N,
  input wire logic I_PORT_A_DIR,
  input wire logic I_PORT_A_STROBE_EN,
  input wire logic I_PORT_A_MAIL_SEL,
  input wire logic [dcf_pkg::DW-1:0] I_PORT_A_BUS,
  output logic [dcf_pkg::DW-1:0] O_PORT_A_BUS,
  output logic O_PORT_A_BUS_OE,
  input wire logic I_PORT_B_CLK,
  input wire logic I_PORT_B_SELECT_N,
  input wire logic I_PORT_B_DIR,
  input wire logic I_PORT_B_STROBE_EN,
  input wire logic I_PORT_B_MAIL_SEL,
  input wire logic [dcf_pkg::DW-1:0] I_PORT_B_BUS,
  output logic [dcf_pkg::DW-1:0] O_PORT_B_BUS,
  output logic O_PORT_B_BUS_OE,
  input wire logic I_RETRANSMIT_MODE_IN,
  input wire logic I_REPLAY_FROM_MARK_IN,
  input wire logic [dcf_pkg::OFS_W-1:0] I_AE_OFFSET,
  input wire logic [dcf_pkg::OFS_W-1:0] I_AF_OFFSET,
  output logic O_INPUT_READY_FLAG,
  output logic O_OUTPUT_READY_FLAG,
  output logic O_ALMOST_EMPTY_FLAG_N,
  output logic O_ALMOST_FULL_FLAG_N,
  output logic O_MAIL_AB_FULL_N,
  output logic O_MAIL_BA_FULL_N
);
  localparam int PAW = dcf_pkg::DW + dcf_pkg::CTL_W + 1;
  localparam int PBW = dcf_pkg::DW + dcf_pkg::CTL_W + 3;
  localparam int PW = dcf_pkg::PW;
  localparam int DW = dcf_pkg::DW;

  // ==========================================================
  // helpers
  function automatic logic [PW-1:0] bin2gray(input logic [PW-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] gray2bin(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = '0;
    b[PW-1] = g[PW-1];
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  // decode of a port access: selected, enabled, given direction and target
  function automatic logic port_hit(input dcf_pkg::dcf_port_ctl_t c,
                                    input logic dir_v, input logic mail_v);
    port_hit = !c.select_n && c.strobe_en && (c.dir == dir_v) &&
               (c.mail_sel == mail_v);
  endfunction

  // ==========================================================
  // pin sampling
  logic [PAW-1:0] pa_level;
  logic [PBW-1:0] pb_level;
  dcf_pkg::dcf_port_ctl_t pa_ctl;
  dcf_pkg::dcf_port_ctl_t pb_ctl;
  logic [DW-1:0] pa_bus;
  logic [DW-1:0] pb_bus;
  logic pa_clk_lv;
  logic pb_clk_lv;
  logic rtm_lv;
  logic rfm_lv;

  dcf_pin_sync #(.W(PAW)) u_sync_a (
    .i_clk(I_MCLK),
    .i_rstn(I_RSTN),
    .i_ce(I_CE),
    .i_pins({I_PORT_A_CLK, ~I_PORT_A_SELECT_N, I_PORT_A_DIR,
             I_PORT_A_STROBE_EN, I_PORT_A_MAIL_SEL, I_PORT_A_BUS}),
    .o_level(pa_level)
  );

  dcf_pin_sync #(.W(PBW)) u_sync_b (
    .i_clk(I_MCLK),
    .i_rstn(I_RSTN),
    .i_ce(I_CE),
    .i_pins({I_PORT_B_CLK, I_RETRANSMIT_MODE_IN, I_REPLAY_FROM_MARK_IN,
             ~I_PORT_B_SELECT_N, I_PORT_B_DIR, I_PORT_B_STROBE_EN,
             I_PORT_B_MAIL_SEL, I_PORT_B_BUS}),
    .o_level(pb_level)
  );

  // unpack the sampled pin groups; selects travel inverted so that
  // the cleared sampler reads as deselected and no bus drives in reset
  assign pa_clk_lv = pa_level[PAW-1];
  assign pa_ctl = pa_level[DW +: dcf_pkg::CTL_W] ^ 4'h8;
  assign pa_bus = pa_level[DW-1:0];
  assign pb_clk_lv = pb_level[PBW-1];
  assign rtm_lv = pb_level[PBW-2];
  assign rfm_lv = pb_level[PBW-3];
  assign pb_ctl = pb_level[DW +: dcf_pkg::CTL_W] ^ 4'h8;
  assign pb_bus = pb_level[DW-1:0];

  // ==========================================================
  // port clock edges
  logic a_clk_prev_q;
  logic b_clk_prev_q;
  logic a_edge;
  logic b_edge;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      a_clk_prev_q <= 1'b0;
      b_clk_prev_q <= 1'b0;
    end else if (I_CE) begin
      a_clk_prev_q <= pa_clk_lv;
      b_clk_prev_q <= pb_clk_lv;
    end
  end

  assign a_edge = I_CE && pa_clk_lv && !a_clk_prev_q;
  assign b_edge = I_CE && pb_clk_lv && !b_clk_prev_q;

  // ==========================================================
  // access decode
  logic ir_flag;
  logic or_q;
  logic a_fifo_wr;
  logic a_mail_wr;
  logic a_mail_rd;
  logic b_fifo_rd;
  logic b_mail_wr;
  logic b_mail_rd;

  assign a_fifo_wr = a_edge && port_hit(pa_ctl, 1'b1, 1'b0) && ir_flag;
  assign a_mail_wr = a_edge && port_hit(pa_ctl, 1'b1, 1'b1);
  assign a_mail_rd = a_edge && port_hit(pa_ctl, 1'b0, 1'b1);
  // port b: direction high reads, low writes
  assign b_fifo_rd = b_edge && port_hit(pb_ctl, 1'b1, 1'b0) && or_q;
  assign b_mail_rd = b_edge && port_hit(pb_ctl, 1'b1, 1'b1);
  assign b_mail_wr = b_edge && port_hit(pb_ctl, 1'b0, 1'b1);

  // ==========================================================
  // mailboxes
  logic [DW-1:0] mail_ab_reg;
  logic [DW-1:0] mail_ba_reg;

  dcf_mailbox #(.W(DW)) u_mail_ab (
    .i_clk(I_MCLK),
    .i_rstn(I_RSTN),
    .i_ce(I_CE),
    .i_wr(a_mail_wr),
    .i_rd(b_mail_rd),
    .i_data(pa_bus),
    .o_data(mail_ab_reg),
    .o_full_n(O_MAIL_AB_FULL_N)
  );

  dcf_mailbox #(.W(DW)) u_mail_ba (
    .i_clk(I_MCLK),
    .i_rstn(I_RSTN),
    .i_ce(I_CE),
    .i_wr(b_mail_wr),
    .i_rd(a_mail_rd),
    .i_data(pb_bus),
    .o_data(mail_ba_reg),
    .o_full_n(O_MAIL_BA_FULL_N)
  );

  // ==========================================================
  // memory and write side
  logic [DW-1:0] mem [dcf_pkg::DEPTH];
  logic [PW-1:0] wr_ptr_q;
  logic [PW-1:0] wr_gray_q;

  always_ff @(posedge I_MCLK) begin
    if (a_fifo_wr) begin
      mem[wr_ptr_q[dcf_pkg::AW-1:0]] <= pa_bus;
    end
  end

  // write pointer and its gray image
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wr_ptr_q <= '0;
      wr_gray_q <= '0;
    end else if (I_CE) begin
      if (a_fifo_wr) begin
        wr_ptr_q <= wr_ptr_q + 1'b1;
      end
      wr_gray_q <= bin2gray(wr_ptr_q);
    end
  end

  // ==========================================================
  // read side: pointer, output register, output ready
  logic [PW-1:0] rd_ptr_q;
  logic [PW-1:0] shadow_q;
  logic [PW-1:0] wr_g1_q;
  logic [PW-1:0] wr_g2_q;
  logic [PW-1:0] wr_in_b;
  logic [PW-1:0] count_b;
  logic [DW-1:0] out_q;
  logic [1:0] reads_q;
  logic load;
  logic replay;
  dcf_pkg::dcf_rtx_state_t rtx_q;

  // write pointer enters the b domain through two b edges
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      wr_g1_q <= '0;
      wr_g2_q <= '0;
    end else if (b_edge) begin
      wr_g1_q <= wr_gray_q;
      wr_g2_q <= wr_g1_q;
    end
  end

  assign wr_in_b = gray2bin(wr_g2_q);
  assign count_b = wr_in_b - rd_ptr_q;
  assign replay = b_edge && (rtx_q == dcf_pkg::RTX_ON) && rtm_lv &&
                  rfm_lv && (reads_q >= 2'(dcf_pkg::RTX_MIN_READS));
  // automatic fall-through while not ready, else selected read
  assign load = b_edge && !replay && (count_b != '0) &&
                (!or_q || b_fifo_rd);

  // read pointer steps on every load, replay restarts after the mark
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rd_ptr_q <= '0;
    end else if (replay) begin
      rd_ptr_q <= shadow_q + 1'b1;
    end else if (load) begin
      rd_ptr_q <= rd_ptr_q + 1'b1;
    end
  end

  // output register keeps the old word unless loaded
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      out_q <= '0;
    end else if (replay) begin
      out_q <= mem[shadow_q[dcf_pkg::AW-1:0]];
    end else if (load) begin
      out_q <= mem[rd_ptr_q[dcf_pkg::AW-1:0]];
    end
  end

  // output ready: raised with a load, dropped by a read with nothing next
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      or_q <= dcf_pkg::OR_RST;
    end else if (load || replay) begin
      or_q <= 1'b1;
    end else if (b_fifo_rd) begin
      or_q <= 1'b0;
    end
  end

  // ==========================================================
  // retransmit control
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rtx_q <= dcf_pkg::RTX_IDLE;
      shadow_q <= '0;
    end else if (b_edge) begin
      unique case (rtx_q)
        dcf_pkg::RTX_IDLE: begin
          if (rtm_lv && or_q) begin
            rtx_q <= dcf_pkg::RTX_ON;
            shadow_q <= rd_ptr_q - 1'b1;
          end
        end
        dcf_pkg::RTX_ON: begin
          if (!rtm_lv) begin
            rtx_q <= dcf_pkg::RTX_IDLE;
          end
        end
        default: begin
          rtx_q <= dcf_pkg::RTX_IDLE;
        end
      endcase
    end
  end

  // reads past the marked word, saturating at the replay threshold
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      reads_q <= '0;
    end else if (b_edge) begin
      if (rtx_q != dcf_pkg::RTX_ON || replay) begin
        reads_q <= '0;
      end else if (load && reads_q < 2'(dcf_pkg::RTX_MIN_READS)) begin
        reads_q <= reads_q + 1'b1;
      end
    end
  end

  // ==========================================================
  // write-side flags from the read pointer seen on port a
  logic [PW-1:0] rd_src;
  logic [PW-1:0] rd_gray_q;
  logic [PW-1:0] rd_g1_q;
  logic [PW-1:0] rd_g2_q;
  logic [PW-1:0] count_a;
  logic [1:0] ir_arm_q;
  logic [PW:0] af_sum;

  // shadow pointer guards marked data while retransmitting
  assign rd_src = (rtx_q == dcf_pkg::RTX_ON) ? shadow_q : rd_ptr_q;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rd_gray_q <= '0;
    end else if (I_CE) begin
      rd_gray_q <= bin2gray(rd_src);
    end
  end

  // read pointer enters the a domain through two a edges
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      rd_g1_q <= '0;
      rd_g2_q <= '0;
    end else if (a_edge) begin
      rd_g1_q <= rd_gray_q;
      rd_g2_q <= rd_g1_q;
    end
  end

  // input ready held low for two a edges after reset
  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      ir_arm_q <= '0;
    end else if (a_edge && ir_arm_q < 2'(dcf_pkg::IR_ARM_EDGES)) begin
      ir_arm_q <= ir_arm_q + 1'b1;
    end
  end

  assign count_a = wr_ptr_q - gray2bin(rd_g2_q);
  assign af_sum = {1'b0, count_a} + (PW + 1)'(I_AF_OFFSET);
  assign ir_flag = (ir_arm_q == 2'(dcf_pkg::IR_ARM_EDGES)) ?
                   !count_a[PW-1] : dcf_pkg::IR_RST;

  // ==========================================================
  // flag outputs
  assign O_INPUT_READY_FLAG = ir_flag;
  assign O_OUTPUT_READY_FLAG = or_q;
  assign O_ALMOST_EMPTY_FLAG_N = count_b > PW'(I_AE_OFFSET);
  assign O_ALMOST_FULL_FLAG_N = af_sum < (PW + 1)'(dcf_pkg::DEPTH);

  // ==========================================================
  // bus drivers
  logic [DW-1:0] a_bus_q;
  logic [DW-1:0] b_bus_q;

  always_ff @(posedge I_MCLK or negedge I_RSTN) begin
    if (!I_RSTN) begin
      a_bus_q <= '0;
      b_bus_q <= '0;
    end else if (I_CE) begin
      a_bus_q <= mail_ba_reg;
      b_bus_q <= pb_ctl.mail_sel ? mail_ab_reg : out_q;
    end
  end

  assign O_PORT_A_BUS = a_bus_q;
  assign O_PORT_A_BUS_OE = !pa_ctl.select_n && !pa_ctl.dir;
  assign O_PORT_B_BUS = b_bus_q;
  assign O_PORT_B_BUS_OE = !pb_ctl.select_n && pb_ctl.dir;

  // ==========================================================
  // checks
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RSTN);

  sequence s_mark;
    b_edge && rtx_q == dcf_pkg::RTX_IDLE && rtm_lv && or_q;
  endsequence

  sequence s_replay;
    replay ##1 (rd_ptr_q == shadow_q + 1'b1);
  endsequence

  AST_OR_RISE_LOADS: assert property ($rose(or_q) |->
    $past(rd_ptr_q) != rd_ptr_q) else $error("ready rose without load");
  AST_READ_IGNORED: assert property (b_edge && !or_q && !replay &&
    count_b == '0 |=> $stable(rd_ptr_q) && $stable(out_q))
    else $error("read not ignored");
  AST_WRITE_IGNORED: assert property (a_edge && !ir_flag |=>
    $stable(wr_ptr_q)) else $error("write taken while not ready");
  AST_AE_ON_B: assert property ($changed(O_ALMOST_EMPTY_FLAG_N) |->
    $past(b_edge)) else $error("almost empty moved off a b edge");
  AST_FULL_FLAGS: assert property (count_a == PW'(dcf_pkg::DEPTH) |->
    !ir_flag && !O_ALMOST_FULL_FLAG_N) else $error("full flags wrong");
  AST_MAIL_AB_READ: assert property (b_mail_rd && !a_mail_wr |=>
    O_MAIL_AB_FULL_N) else $error("a-to-b mailbox not freed");
  AST_MAIL_BA_READ: assert property (a_mail_rd && !b_mail_wr |=>
    O_MAIL_BA_FULL_N) else $error("b-to-a mailbox not freed");
  AST_MARK: assert property (s_mark |=> rtx_q == dcf_pkg::RTX_ON &&
    shadow_q == $past(rd_ptr_q) - 1'b1) else $error("mark wrong");
  AST_REPLAY: assert property (replay |-> s_replay)
    else $error("replay did not restart at mark");
  AST_EXIT: assert property (b_edge && rtx_q == dcf_pkg::RTX_ON && !rtm_lv
    |=> rtx_q == dcf_pkg::RTX_IDLE) else $error("retransmit not left");
endmodule

// *** dcf_host_model.sv ***
`timescale 1ns/1ps
// ============================================================
// port host model: free-running port clock, one access per call
module dcf_host_model #(
  parameter int PHASE = 0
) (
  input wire logic i_mclk,
  output logic o_pclk,
  output dcf_pkg::dcf_port_ctl_t o_ctl,
  output logic [35:0] o_data
);
  logic [2:0] cnt_q = 3'(PHASE);
  // port clock at one eighth of the system clock, never stopped
  always @(posedge i_mclk) begin
    cnt_q <= cnt_q + 3'h1;
  end
  assign o_pclk = cnt_q[2];
  // start deselected
  initial begin
    o_ctl = dcf_pkg::dcf_port_ctl_t'(4'h8);
    o_data = 36'h0;
  end
  // wait falling port edges; controls change there, far from sampling
  task automatic idle(input int n);
    repeat (n) @(negedge o_pclk);
    #2;
  endtask
  // hold controls over one rising edge, then drop the enable;
  // released data shows the inverse so a stale value never matches
  task automatic access(input logic [3:0] c, input logic [35:0] d);
    idle(1);
    o_ctl = dcf_pkg::dcf_port_ctl_t'(c);
    o_data = d;
    idle(1);
    o_ctl.strobe_en = 1'b0;
    o_data = ~d;
    idle(1);
  endtask
endmodule

// *** tb.sv ***
`timescale 1ns/1ps
module tb;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic retransmit_mode_in = 1'b0;
  logic replay_from_mark_in = 1'b0;
  logic ce = 1'b1;
  logic [9:0] ae_ofs = 10'h003;
  logic [9:0] af_ofs = 10'h004;
  logic pclk_a;
  logic pclk_b;
  dcf_pkg::dcf_port_ctl_t ctl_a;
  dcf_pkg::dcf_port_ctl_t ctl_b;
  logic [35:0] din_a;
  logic [35:0] din_b;
  logic [35:0] dout_a;
  logic [35:0] dout_b;
  logic oe_a, oe_b, ir, orf, ae_n, af_n, mab_n, mba_n;
  int failures = 0;
  int n_checks = 0;
  int i;
  // ============================================================
  // clock, hosts and device
  always #12.5 mclk = ~mclk;
  dcf_host_model #(.PHASE(0)) i_host_a (.i_mclk(mclk), .o_pclk(pclk_a),
    .o_ctl(ctl_a), .o_data(din_a));
  dcf_host_model #(.PHASE(3)) i_host_b (.i_mclk(mclk), .o_pclk(pclk_b),
    .o_ctl(ctl_b), .o_data(din_b));
  dcf_fifo i_dut (
    .I_MCLK(mclk), .I_RSTN(rstn), .I_CE(ce), .I_PORT_A_CLK(pclk_a),
    .I_PORT_A_SELECT_N(ctl_a.select_n), .I_PORT_A_DIR(ctl_a.dir),
    .I_PORT_A_STROBE_EN(ctl_a.strobe_en), .I_PORT_A_MAIL_SEL(ctl_a.mail_sel),
    .I_PORT_A_BUS(din_a), .O_PORT_A_BUS(dout_a), .O_PORT_A_BUS_OE(oe_a),
    .I_PORT_B_CLK(pclk_b), .I_PORT_B_SELECT_N(ctl_b.select_n),
    .I_PORT_B_DIR(ctl_b.dir), .I_PORT_B_STROBE_EN(ctl_b.strobe_en),
    .I_PORT_B_MAIL_SEL(ctl_b.mail_sel), .I_PORT_B_BUS(din_b),
    .O_PORT_B_BUS(dout_b), .O_PORT_B_BUS_OE(oe_b),
    .I_RETRANSMIT_MODE_IN(retransmit_mode_in), .I_REPLAY_FROM_MARK_IN(replay_from_mark_in),
    .I_AE_OFFSET(ae_ofs), .I_AF_OFFSET(af_ofs),
    .O_INPUT_READY_FLAG(ir), .O_OUTPUT_READY_FLAG(orf),
    .O_ALMOST_EMPTY_FLAG_N(ae_n), .O_ALMOST_FULL_FLAG_N(af_n),
    .O_MAIL_AB_FULL_N(mab_n), .O_MAIL_BA_FULL_N(mba_n));
  // ============================================================
  // helpers
  function automatic logic [35:0] wd(input int n);
    return 36'(n) ^ 36'h5a5a00000;
  endfunction
  task automatic check(input string name, input logic [35:0] seen,
                       input logic [35:0] want);
    n_checks++;
    if (seen !== want) begin
      failures++;
      $display("Error %s expected %h seen %h", name, want, seen);
    end
  endtask
  task automatic wrap_up();
    if (failures == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // bounded wait for input ready (0) or output ready (1)
  task automatic wait_hi(input int f);
    int k;
    for (k = 0; k < 40; k++) begin
      if ((f == 0 ? ir : orf) === 1'b1) break;
      i_host_b.idle(1);
    end
    if (k == 40) begin
      failures++;
      wrap_up();
    end
  endtask
  // retransmit and replay inputs held across one port b rising edge
  task automatic rtx(input logic m, input logic r);
    @(negedge pclk_b);
    #2;
    retransmit_mode_in = m;
    replay_from_mark_in = r;
  endtask
  // run limit
  initial begin
    #2400000;
    failures++;
    wrap_up();
  end
  // ============================================================
  // main sequence
  initial begin
    repeat (4) @(posedge mclk);
    #2;
    check("reset flags", {ir, orf, ae_n, af_n, mab_n, mba_n}, 36'h7);
    repeat (6) @(posedge mclk);
    #2;
    rstn = 1'b1;
    wait_hi(0);
    check("empty flags", {ir, orf, ae_n, af_n}, 36'h9);
    // mailboxes in both directions, second write while full dropped
    i_host_a.access(4'h7, 36'h123456789);
    check("mab_n", mab_n, 1'b0);
    i_host_a.access(4'h7, 36'h0abcdef01);
    i_host_b.access(4'h7, 36'h0);
    check("b mail", dout_b, 36'h123456789);
    check("mab_n", mab_n, 1'b1);
    check("oe_b", oe_b, 1'b1);
    i_host_b.access(4'h3, 36'h0fedcba98);
    check("mba_n", mba_n, 1'b0);
    check("oe_b", oe_b, 1'b0);
    i_host_a.access(4'h3, 36'h0);
    check("a mail", dout_a, 36'h0fedcba98);
    check("mba_n", mba_n, 1'b1);
    check("oe_a", oe_a, 1'b1);
    // clock enable low: a mailbox write strobe must leave no trace
    ce = 1'b0;
    i_host_a.access(4'h7, 36'h0);
    ce = 1'b1;
    i_host_a.idle(2);
    check("frozen mab_n", mab_n, 1'b1);
    // fill: held word not counted, then overfill by one
    for (i = 0; i < 4; i++) i_host_a.access(4'h6, wd(i));
    check("oe_a", oe_a, 1'b0);
    wait_hi(1);
    i_host_b.access(4'h4, 36'h0);
    check("ae_n", ae_n, 1'b0);
    check("fall through", dout_b, wd(0));
    i_host_a.access(4'h6, wd(4));
    i_host_b.idle(3);
    check("ae_n", ae_n, 1'b1);
    for (i = 5; i < 1026; i++) i_host_a.access(4'h6, wd(i));
    check("full flags", {ir, af_n}, 36'h0);
    // drain in order; the dropped word must never appear
    for (i = 0; i < 1025; i++) begin
      check("fifo data", dout_b, wd(i));
      i_host_b.access(4'h6, 36'h0);
      if (i < 5) begin
        i_host_a.idle(3);
        check("ir", ir, 1'b1);
        check("af_n", af_n, i == 4);
      end
    end
    check("drained flags", {orf, ae_n, af_n, ir}, 36'h3);
    i_host_b.access(4'h6, 36'h0);
    check("ignored read", dout_b, wd(1024));
    // retransmit of a five word sequence
    for (i = 0; i < 5; i++) i_host_a.access(4'h6, wd(2000 + i));
    wait_hi(1);
    i_host_b.idle(1);
    check("first word", dout_b, wd(2000));
    rtx(1'b1, 1'b0);
    i_host_b.access(4'h6, 36'h0);
    i_host_b.access(4'h6, 36'h0);
    check("third word", dout_b, wd(2002));
    rtx(1'b1, 1'b1);
    rtx(1'b1, 1'b0);
    i_host_b.idle(1);
    check("replayed word", dout_b, wd(2000));
    i_host_b.access(4'h6, 36'h0);
    check("after replay", dout_b, wd(2001));
    rtx(1'b0, 1'b0);
    rtx(1'b0, 1'b1);
    rtx(1'b0, 1'b0);
    i_host_b.idle(1);
    check("no replay", dout_b, wd(2001));
    i_host_b.access(4'h6, 36'h0);
    check("resumed", dout_b, wd(2002));
    wrap_up();
  end
endmodule
